// >>> pdsr_defs.svh
// constants for the phy diagnostic and status register bank
`ifndef PDSR_DEFS_SVH
`define PDSR_DEFS_SVH

// ============================================================
// register offsets on the management bus
`define PDSR_REG_EVT 5'h1b
`define PDSR_REG_CBL 5'h1d
`define PDSR_REG_CTL1 5'h1e

// ============================================================
// field positions
`define PDSR_EVT_LPACK_BIT 3
`define PDSR_EVT_LDOWN_BIT 2
`define PDSR_EVT_RFAULT_BIT 1
`define PDSR_EVT_LUP_BIT 0
`define PDSR_EN_LSB 8
`define PDSR_EN_MSB 11
`define PDSR_CBL_START_BIT 15
`define PDSR_LED_MODE_LSB 14
`define PDSR_LED_MODE_MSB 15
`define PDSR_LOOPBACK_BIT 7

// ============================================================
// reset values and codes
`define PDSR_EVT_RST 4'h0
`define PDSR_EN_RST 4'h0
`define PDSR_CBL_RES_RST 2'h0
`define PDSR_CBL_DIST_RST 9'h000
`define PDSR_LED_MODE_RST 2'h0
`define PDSR_LED_SPEED_LINKACT 2'h0
`define PDSR_LED_ACT_LINK 2'h1

// ============================================================
// management frame timing, counted in management clock bits, and frame opcodes
`define PDSR_PRE_LEN 6'h20
`define PDSR_HDR_LAST 6'h0b
`define PDSR_RD_LAST 6'h10
`define PDSR_WR_LAST 6'h11
`define PDSR_OP_RD 2'h2
`define PDSR_OP_WR 2'h1

`endif

// >>> pdsr_mdio_host.sv
// management bus host model that clocks frames into the register bank
module pdsr_mdio_host #(
    parameter logic [4:0] PHY_ADDR = 5'h01
) (
    input wire logic mclk,
    input wire logic mdio_wire,
    output logic mdc,
    output logic host_drv,
    output logic host_en
);
    timeunit 1ns;
    timeprecision 1ps;

    // ============================================================
    // idle state: clock parked, data line left to its pull-up
    initial begin
        mdc = 1'b0;
        host_drv = 1'b1;
        host_en = 1'b0;
    end

    // ============================================================
    // one bit period: low 4 mclk, high 5 mclk, so the slave's
    // two-flop synchroniser always sees both halves
    task automatic bit_cyc(input logic en, input logic b, output logic s);
        @(negedge mclk);
        mdc = 1'b0;
        host_en = en;
        host_drv = b;
        repeat (4) @(negedge mclk);
        s = mdio_wire;
        mdc = 1'b1;
        repeat (4) @(negedge mclk);
    endtask : bit_cyc

    // ============================================================
    // whole frame; every frame carries its own preamble
    task automatic frame(input logic [1:0] op, input logic [4:0] addr, input logic [15:0] wd,
                         output logic [15:0] rd);
        logic [13:0] hdr;
        logic s;
        logic wr_op;
        hdr = {2'h1, op, PHY_ADDR, addr};
        wr_op = (op == 2'h1);
        rd = 16'h0000;
        repeat (32) bit_cyc(1'b1, 1'b1, s);
        for (int i = 13; i >= 0; i--) begin
            bit_cyc(1'b1, hdr[i], s);
        end
        // read turnaround: line released so the slave can take it over
        bit_cyc(wr_op, 1'b1, s);
        bit_cyc(wr_op, 1'b0, s);
        for (int i = 15; i >= 0; i--) begin
            bit_cyc(wr_op, wd[i], s);
            rd[i] = s;
        end
        @(negedge mclk);
        host_en = 1'b0;
    endtask : frame
endmodule : pdsr_mdio_host

// >>> pdsr_mdio_slave.sv
// serial management frame engine for the register bank
`include "pdsr_defs.svh"

module pdsr_mdio_slave #(
    parameter logic [4:0] PHY_ADDR = 5'h01
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic mdc_s,
    input wire logic mdio_s,
    input wire logic [15:0] rd_data,
    output pdsr_pkg::pdsr_reg_req_s req,
    output logic mdio_out,
    output logic mdio_oe_n
);

    pdsr_pkg::pdsr_mdio_state_e state_r, state_nxt;
    pdsr_pkg::pdsr_reg_req_s req_r, req_nxt;
    logic [5:0] cnt_r, cnt_nxt;
    logic [15:0] shift_r, shift_nxt;
    logic mdc_d_r, op_rd_r, op_rd_nxt, out_r, out_nxt, oe_n_r, oe_n_nxt;
    logic rise;
    logic [11:0] hdr;

    // ============================================================
    // frame decode; preamble of 32 ones is required before every frame
    always_comb begin
        rise = mdc_s & ~mdc_d_r;
        hdr = {shift_r[10:0], mdio_s};
        state_nxt = state_r;
        req_nxt = req_r;
        req_nxt.wr = 1'b0;
        req_nxt.rd = 1'b0;
        cnt_nxt = cnt_r;
        shift_nxt = shift_r;
        op_rd_nxt = op_rd_r;
        out_nxt = out_r;
        oe_n_nxt = oe_n_r;
        unique case (state_r)
            pdsr_pkg::PDSR_IDLE: begin
                if (rise) begin
                    if (mdio_s) begin
                        cnt_nxt = (cnt_r == `PDSR_PRE_LEN) ? cnt_r : cnt_r + 6'h01;
                    end else begin
                        if (cnt_r == `PDSR_PRE_LEN) begin
                            state_nxt = pdsr_pkg::PDSR_START;
                        end
                        cnt_nxt = 6'h00;
                    end
                end
            end
            pdsr_pkg::PDSR_START: begin
                if (rise) begin
                    state_nxt = mdio_s ? pdsr_pkg::PDSR_HDR : pdsr_pkg::PDSR_IDLE;
                    cnt_nxt = 6'h00;
                end
            end
            pdsr_pkg::PDSR_HDR: begin
                if (rise) begin
                    shift_nxt = {shift_r[14:0], mdio_s};
                    cnt_nxt = cnt_r + 6'h01;
                    if (cnt_r == `PDSR_HDR_LAST) begin
                        cnt_nxt = 6'h00;
                        // frames for another address are left alone
                        if (hdr[9:5] == PHY_ADDR && (hdr[11:10] == `PDSR_OP_RD || hdr[11:10] == `PDSR_OP_WR)) begin
                            state_nxt = pdsr_pkg::PDSR_LATCH;
                            req_nxt.addr = hdr[4:0];
                            op_rd_nxt = (hdr[11:10] == `PDSR_OP_RD);
                        end else begin
                            state_nxt = pdsr_pkg::PDSR_IDLE;
                        end
                    end
                end
            end
            pdsr_pkg::PDSR_LATCH: begin
                // the read value travels with the strobe so that only bits seen are cleared
                if (op_rd_r) begin
                    shift_nxt = rd_data;
                    req_nxt.rd = 1'b1;
                    req_nxt.wdata = rd_data;
                    state_nxt = pdsr_pkg::PDSR_TA;
                end else begin
                    state_nxt = pdsr_pkg::PDSR_WDATA;
                end
            end
            pdsr_pkg::PDSR_TA: begin
                if (rise) begin
                    out_nxt = 1'b0;
                    oe_n_nxt = 1'b0;
                    state_nxt = pdsr_pkg::PDSR_RDATA;
                end
            end
            pdsr_pkg::PDSR_RDATA: begin
                if (rise) begin
                    if (cnt_r == `PDSR_RD_LAST) begin
                        out_nxt = 1'b0;
                        oe_n_nxt = 1'b1;
                        cnt_nxt = 6'h00;
                        state_nxt = pdsr_pkg::PDSR_IDLE;
                    end else begin
                        out_nxt = shift_r[15];
                        shift_nxt = {shift_r[14:0], 1'b0};
                        cnt_nxt = cnt_r + 6'h01;
                    end
                end
            end
            pdsr_pkg::PDSR_WDATA: begin
                if (rise) begin
                    shift_nxt = {shift_r[14:0], mdio_s};
                    cnt_nxt = cnt_r + 6'h01;
                    if (cnt_r == `PDSR_WR_LAST) begin
                        req_nxt.wr = 1'b1;
                        req_nxt.wdata = {shift_r[14:0], mdio_s};
                        cnt_nxt = 6'h00;
                        state_nxt = pdsr_pkg::PDSR_IDLE;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state_r <= pdsr_pkg::PDSR_IDLE;
            req_r <= '0;
            cnt_r <= 6'h00;
            shift_r <= 16'h0000;
            mdc_d_r <= 1'b0;
            op_rd_r <= 1'b0;
            out_r <= 1'b0;
            oe_n_r <= 1'b1;
        end else begin
            state_r <= state_nxt;
            req_r <= req_nxt;
            cnt_r <= cnt_nxt;
            shift_r <= shift_nxt;
            mdc_d_r <= mdc_s;
            op_rd_r <= op_rd_nxt;
            out_r <= out_nxt;
            oe_n_r <= oe_n_nxt;
        end
    end

    assign req = req_r;
    assign mdio_out = out_r;
    assign mdio_oe_n = oe_n_r;

    // ============================================================
    // checks
    turnaround_drive_a: assert property (@(posedge mclk) disable iff (rst)
        (state_r == pdsr_pkg::PDSR_TA && rise) |=> (!oe_n_r && !out_r))
        else $error("read turnaround not driven low");

endmodule : pdsr_mdio_slave

// >>> pdsr_pkg.sv
// types shared by the phy diagnostic and status register bank
package pdsr_pkg;

    // ============================================================
    // serial management frame states
    typedef enum logic [2:0] {
        PDSR_IDLE,
        PDSR_START,
        PDSR_HDR,
        PDSR_LATCH,
        PDSR_TA,
        PDSR_RDATA,
        PDSR_WDATA
    } pdsr_mdio_state_e;

    // ============================================================
    // live status from the line side
    typedef struct packed {
        logic link_ok;
        logic lp_ack;
        logic remote_fault;
        logic cable_done;
        logic [1:0] cable_result;
        logic [8:0] cable_dist;
        logic polarity_rev;
        logic far_end_fault;
        logic fiber_mode;
        logic crossover;
        logic speed100;
        logic activity;
    } pdsr_phy_stat_s;

    // register access decoded from a management frame
    typedef struct packed {
        logic wr;
        logic rd;
        logic [4:0] addr;
        logic [15:0] wdata;
    } pdsr_reg_req_s;

endpackage : pdsr_pkg

// >>> pdsr_regs.sv
// phy diagnostic and status register bank behind the serial management bus
// ============================================================
// Summary of operation
// - link partner acknowledge sets event bit 3; zero otherwise and after reset.
// - link dropping sets event bit 2; zero otherwise and after reset.
// - remote fault sets event bit 1; zero otherwise and after reset.
// - link coming up sets event bit 0; zero otherwise and after reset.
// - enable bits 11:8 pass matching events to the interrupt output.
// - writing one to cable test bit 15 starts the test; resets to zero.
// - start bit self-clears at test end; zero means result and distance valid.
// - result bits 14:13: normal, open, short, failed; read-only, reset zero.
// - nine-bit read-only fault distance in bits 8:0, about 0.4 m per count.
// - led mode bits 15:14 choose what the two indicator outputs show.
// - read-only bit 13 shows reversed receive polarity.
// - read-only bit 12 flags far-end fault, in fiber operation only.
// - read-only bit 11 shows straight-through zero or crossover one.
// - read-write bit 7 selects remote analog loopback; zero is normal.
`include "pdsr_defs.svh"

module pdsr_regs #(
    parameter logic [4:0] PHY_ADDR = 5'h01
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic mdc,
    input wire logic mdio_in,
    input pdsr_pkg::pdsr_phy_stat_s stat,
    output logic mdio_out,
    output logic mdio_oe_n,
    output logic indicator_out_a,
    output logic indicator_out_b,
    output logic intr_out,
    output logic cable_test_start,
    output logic remote_loopback
);

    localparam int SW = $bits(pdsr_pkg::pdsr_phy_stat_s) + 2;

    // ============================================================
    // synchronisers; multi-bit cable results must be stable before done rises
    logic [SW-1:0] raw, s1_r, s2_r;
    assign raw = {mdc, mdio_in, stat};

    genvar gi;
    generate
        for (gi = 0; gi < SW; gi++) begin : g_sync
            always_ff @(posedge mclk or posedge rst) begin
                if (rst) begin
                    s1_r[gi] <= 1'b0;
                    s2_r[gi] <= 1'b0;
                end else begin
                    s1_r[gi] <= raw[gi];
                    s2_r[gi] <= s1_r[gi];
                end
            end
        end
    endgenerate

    pdsr_pkg::pdsr_phy_stat_s st_s, prev_r;
    assign st_s = pdsr_pkg::pdsr_phy_stat_s'(s2_r[SW-3:0]);

    // ============================================================
    // management frame engine
    pdsr_pkg::pdsr_reg_req_s req;
    logic [15:0] rd_data;

    pdsr_mdio_slave #(
        .PHY_ADDR(PHY_ADDR)
    ) u_mdio (
        .mclk(mclk),
        .rst(rst),
        .mdc_s(s2_r[SW-1]),
        .mdio_s(s2_r[SW-2]),
        .rd_data(rd_data),
        .req(req),
        .mdio_out(mdio_out),
        .mdio_oe_n(mdio_oe_n)
    );

    // ============================================================
    // register state
    logic [3:0] evt_r, evt_nxt, en_r, en_nxt, set, clr;
    logic cbl_start_r, cbl_start_nxt, loop_r, loop_nxt, led_a_r, led_a_nxt, led_b_r, led_b_nxt, intr_r, intr_nxt;
    logic [1:0] cbl_res_r, cbl_res_nxt, led_mode_r, led_mode_nxt;
    logic [8:0] cbl_dist_r, cbl_dist_nxt;
    logic fef, cbl_done_rise, wr_evt, wr_cbl, wr_ctl;
    logic [2:0] arm_r, arm_nxt;
    logic armed;

    always_comb begin
        fef = st_s.fiber_mode & st_s.far_end_fault;
        wr_evt = req.wr && req.addr == `PDSR_REG_EVT;
        wr_cbl = req.wr && req.addr == `PDSR_REG_CBL;
        wr_ctl = req.wr && req.addr == `PDSR_REG_CTL1;
        unique case (req.addr)
            `PDSR_REG_EVT: rd_data = {4'h0, en_r, 4'h0, evt_r};
            `PDSR_REG_CBL: rd_data = {cbl_start_r, cbl_res_r, 4'h0, cbl_dist_r};
            `PDSR_REG_CTL1: rd_data = {led_mode_r, st_s.polarity_rev, fef, st_s.crossover, 3'h0, loop_r, 7'h00};
            default: rd_data = 16'h0000;
        endcase
        // edges wait until both sync stages and prev_r hold pin levels, else a level present at reset reads as an event
        arm_nxt = {arm_r[1:0], 1'b1};
        armed = arm_r[2];
        set[`PDSR_EVT_LPACK_BIT] = armed & st_s.lp_ack & ~prev_r.lp_ack;
        set[`PDSR_EVT_LDOWN_BIT] = armed & ~st_s.link_ok & prev_r.link_ok;
        set[`PDSR_EVT_RFAULT_BIT] = armed & st_s.remote_fault & ~prev_r.remote_fault;
        set[`PDSR_EVT_LUP_BIT] = armed & st_s.link_ok & ~prev_r.link_ok;
        // only the bits returned by the read are cleared, and a new event wins
        clr = (req.rd && req.addr == `PDSR_REG_EVT) ? req.wdata[3:0] : 4'h0;
        evt_nxt = (evt_r & ~clr) | set;
        en_nxt = wr_evt ? req.wdata[`PDSR_EN_MSB:`PDSR_EN_LSB] : en_r;
        intr_nxt = |(evt_nxt & en_nxt);
        cbl_done_rise = armed & st_s.cable_done & ~prev_r.cable_done;
        cbl_start_nxt = cbl_start_r;
        cbl_res_nxt = cbl_res_r;
        cbl_dist_nxt = cbl_dist_r;
        if (cbl_start_r && cbl_done_rise) begin
            cbl_start_nxt = 1'b0;
            cbl_res_nxt = st_s.cable_result;
            cbl_dist_nxt = st_s.cable_dist;
        end
        // a running test cannot be aborted; writing zero has no effect
        if (wr_cbl && req.wdata[`PDSR_CBL_START_BIT]) begin
            cbl_start_nxt = 1'b1;
        end
        led_mode_nxt = wr_ctl ? req.wdata[`PDSR_LED_MODE_MSB:`PDSR_LED_MODE_LSB] : led_mode_r;
        loop_nxt = wr_ctl ? req.wdata[`PDSR_LOOPBACK_BIT] : loop_r;
        // reserved modes keep both indicators dark
        unique case (led_mode_r)
            `PDSR_LED_SPEED_LINKACT: begin
                led_b_nxt = st_s.speed100;
                led_a_nxt = st_s.link_ok & ~st_s.activity;
            end
            `PDSR_LED_ACT_LINK: begin
                led_b_nxt = st_s.activity;
                led_a_nxt = st_s.link_ok;
            end
            default: begin
                led_b_nxt = 1'b0;
                led_a_nxt = 1'b0;
            end
        endcase
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            prev_r <= '0;
            arm_r <= 3'h0;
            evt_r <= `PDSR_EVT_RST;
            en_r <= `PDSR_EN_RST;
            intr_r <= 1'b0;
            cbl_start_r <= 1'b0;
            cbl_res_r <= `PDSR_CBL_RES_RST;
            cbl_dist_r <= `PDSR_CBL_DIST_RST;
            led_mode_r <= `PDSR_LED_MODE_RST;
            loop_r <= 1'b0;
            led_a_r <= 1'b0;
            led_b_r <= 1'b0;
        end else begin
            prev_r <= st_s;
            arm_r <= arm_nxt;
            evt_r <= evt_nxt;
            en_r <= en_nxt;
            intr_r <= intr_nxt;
            cbl_start_r <= cbl_start_nxt;
            cbl_res_r <= cbl_res_nxt;
            cbl_dist_r <= cbl_dist_nxt;
            led_mode_r <= led_mode_nxt;
            loop_r <= loop_nxt;
            led_a_r <= led_a_nxt;
            led_b_r <= led_b_nxt;
        end
    end

    assign indicator_out_a = led_a_r;
    assign indicator_out_b = led_b_r;
    assign intr_out = intr_r;
    assign cable_test_start = cbl_start_r;
    assign remote_loopback = loop_r;

    // ============================================================
    // checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    sequence cbl_start_wr;
        wr_cbl && req.wdata[`PDSR_CBL_START_BIT];
    endsequence

    sequence cbl_finish;
        cbl_start_r && cbl_done_rise && !wr_cbl;
    endsequence

    lp_ack_flag_a: assert property (armed && st_s.lp_ack && !prev_r.lp_ack |=> evt_r[3])
        else $error("partner acknowledge flag not set");
    link_down_flag_a: assert property (armed && !st_s.link_ok && prev_r.link_ok |=> evt_r[2])
        else $error("link down flag not set");
    rfault_flag_a: assert property (armed && st_s.remote_fault && !prev_r.remote_fault |=> evt_r[1])
        else $error("remote fault flag not set");
    link_up_flag_a: assert property (armed && st_s.link_ok && !prev_r.link_ok |=> evt_r[0])
        else $error("link up flag not set");
    reset_quiet_a: assert property (!armed |=> evt_r == 4'h0)
        else $error("event flag set while edge detectors arm");
    read_clear_a: assert property ((req.rd && req.addr == `PDSR_REG_EVT && set == 4'h0) |=> ((evt_r & $past(req.wdata[3:0])) == 4'h0))
        else $error("event flags not cleared by read");
    intr_gate_a: assert property ((|(set & en_r)) && !wr_evt |=> intr_out)
        else $error("enabled event did not raise the interrupt output");
    intr_quiet_a: assert property (en_r == 4'h0 && !wr_evt |=> !intr_out)
        else $error("interrupt output raised with no event enabled");
    cable_start_a: assert property (cbl_start_wr |=> cable_test_start)
        else $error("cable test not started by write");
    cable_done_a: assert property (cbl_finish |=> (!cable_test_start && cbl_res_r == $past(st_s.cable_result) && cbl_dist_r == $past(st_s.cable_dist)))
        else $error("cable test end not recorded");
    led_act_link_a: assert property ((led_mode_r == `PDSR_LED_ACT_LINK && !wr_ctl) |=> (indicator_out_b == $past(st_s.activity) && indicator_out_a == $past(st_s.link_ok)))
        else $error("indicators wrong in activity and link mode");
    fef_copper_a: assert property ((!st_s.fiber_mode && req.addr == `PDSR_REG_CTL1) |-> !rd_data[12])
        else $error("far-end fault shown outside fiber operation");
    loopback_wr_a: assert property (wr_ctl |=> remote_loopback == $past(req.wdata[`PDSR_LOOPBACK_BIT]))
        else $error("loopback bit not written");

endmodule : pdsr_regs

// >>> pdsr_regs_tb_top.sv
// self-checking bench for the phy diagnostic and status register bank
`include "pdsr_defs.svh"

module pdsr_regs_tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    logic mclk;
    logic rst;
    logic mdc;
    logic mdio_in;
    logic host_drv;
    logic host_en;
    pdsr_pkg::pdsr_phy_stat_s stat;
    logic mdio_out;
    logic mdio_oe_n;
    logic indicator_out_a;
    logic indicator_out_b;
    logic intr_out;
    logic cable_test_start;
    logic remote_loopback;
    logic [15:0] rv;
    int miscompares;
    int total_checks;
    logic [1:0] led_exp [4] = '{2'h1, 2'h3, 2'h0, 2'h0};

    // ============================================================
    // wire level: slave wins, then host, else the pull-up
    assign mdio_in = !mdio_oe_n ? mdio_out : (host_en ? host_drv : 1'b1);

    pdsr_regs dut (.mclk(mclk), .rst(rst), .mdc(mdc), .mdio_in(mdio_in), .stat(stat),
        .mdio_out(mdio_out), .mdio_oe_n(mdio_oe_n), .indicator_out_a(indicator_out_a),
        .indicator_out_b(indicator_out_b), .intr_out(intr_out),
        .cable_test_start(cable_test_start), .remote_loopback(remote_loopback));

    pdsr_mdio_host host (.mclk(mclk), .mdio_wire(mdio_in), .mdc(mdc), .host_drv(host_drv),
        .host_en(host_en));

    always #20 mclk = ~mclk;

    // ============================================================
    // access and compare tasks
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic rd(input logic [4:0] a);
        host.frame(`PDSR_OP_RD, a, 16'h0000, rv);
    endtask : rd

    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        logic [15:0] unused;
        host.frame(`PDSR_OP_WR, a, d, unused);
        repeat (3) @(negedge mclk);
    endtask : wr

    task automatic settle();
        repeat (6) @(negedge mclk);
    endtask : settle

    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : stop_test

    // a hung frame must not stall the run forever
    initial begin
        repeat (100000) @(posedge mclk);
        miscompares++;
        stop_test();
    end

    // ============================================================
    // main sequence
    initial begin
        mclk = 1'b0;
        rst = 1'b1;
        stat = '0;
        miscompares = 0;
        total_checks = 0;
        repeat (2) @(negedge mclk);
        rst = 1'b0;
        repeat (3) @(negedge mclk);
        chk({11'h000, intr_out, cable_test_start, remote_loopback, indicator_out_a, indicator_out_b},
            16'h0000);
        rd(`PDSR_REG_EVT);
        chk(rv, 16'h0000);
        rd(`PDSR_REG_CTL1);
        chk(rv, 16'h0000);
        wr(5'h1c, 16'hffff);
        rd(`PDSR_REG_CBL);
        chk(rv, 16'h0000);
        $display("reset values done");

        stat.lp_ack = 1'b1;
        stat.remote_fault = 1'b1;
        stat.link_ok = 1'b1;
        settle();
        rd(`PDSR_REG_EVT);
        chk(rv, 16'h000b);
        rd(`PDSR_REG_EVT);
        chk(rv, 16'h0000);
        stat.link_ok = 1'b0;
        settle();
        rd(`PDSR_REG_EVT);
        chk(rv, 16'h0004);
        wr(`PDSR_REG_EVT, 16'hffff);
        rd(`PDSR_REG_EVT);
        chk(rv, 16'h0f00);
        stat.lp_ack = 1'b0;
        stat.remote_fault = 1'b0;
        stat.link_ok = 1'b1;
        settle();
        chk({15'h0000, intr_out}, 16'h0001);
        rd(`PDSR_REG_EVT);
        chk(rv, 16'h0f01);
        chk({15'h0000, intr_out}, 16'h0000);
        wr(`PDSR_REG_EVT, 16'h0e00);
        stat.link_ok = 1'b0;
        settle();
        chk({15'h0000, intr_out}, 16'h0001);
        rd(`PDSR_REG_EVT);
        chk(rv, 16'h0e04);
        stat.link_ok = 1'b1;
        settle();
        chk({15'h0000, intr_out}, 16'h0000);
        rd(`PDSR_REG_EVT);
        chk(rv, 16'h0e01);
        $display("event flags done");

        wr(`PDSR_REG_CBL, 16'h8000);
        rd(`PDSR_REG_CBL);
        chk(rv, 16'h8000);
        // every result code, with the top distance bit exercised too
        for (int r = 0; r < 4; r++) begin
            wr(`PDSR_REG_CBL, 16'h8000);
            chk({15'h0000, cable_test_start}, 16'h0001);
            stat.cable_result = r[1:0];
            stat.cable_dist = {r[1:0], 7'h35};
            repeat (4) @(negedge mclk);
            stat.cable_done = 1'b1;
            settle();
            stat.cable_done = 1'b0;
            chk({15'h0000, cable_test_start}, 16'h0000);
            rd(`PDSR_REG_CBL);
            chk(rv, {1'b0, r[1:0], 4'h0, r[1:0], 7'h35});
        end
        wr(`PDSR_REG_CBL, 16'h7fff);
        rd(`PDSR_REG_CBL);
        chk(rv, 16'h61b5);
        $display("cable test done");

        stat.polarity_rev = 1'b1;
        stat.far_end_fault = 1'b1;
        stat.crossover = 1'b1;
        wr(`PDSR_REG_CTL1, 16'hffff);
        settle();
        rd(`PDSR_REG_CTL1);
        chk(rv, 16'he880);
        chk({15'h0000, remote_loopback}, 16'h0001);
        stat.fiber_mode = 1'b1;
        stat.polarity_rev = 1'b0;
        stat.crossover = 1'b0;
        settle();
        rd(`PDSR_REG_CTL1);
        chk(rv, 16'hd080);
        stat.activity = 1'b1;
        stat.speed100 = 1'b1;
        for (int m = 0; m < 4; m++) begin
            wr(`PDSR_REG_CTL1, {m[1:0], 14'h0000});
            chk({14'h0000, indicator_out_a, indicator_out_b}, {14'h0000, led_exp[m]});
        end
        chk({15'h0000, remote_loopback}, 16'h0000);
        rd(`PDSR_REG_CTL1);
        chk(rv, 16'hd000);
        $display("control register done");

        // second reset in mid-run must restore the writable fields
        rst = 1'b1;
        repeat (2) @(negedge mclk);
        rst = 1'b0;
        repeat (3) @(negedge mclk);
        rd(`PDSR_REG_CTL1);
        chk(rv, 16'h1000);
        rd(`PDSR_REG_EVT);
        chk(rv, 16'h0000);
        $display("second reset done");
        stop_test();
    end
endmodule : pdsr_regs_tb_top
